// [hw/pia_defs.svh]
// register offsets, field positions, masks and reset values of the interrupt arbiter
`ifndef PIA_DEFS_SVH
`define PIA_DEFS_SVH
`define PIA_OFF_CTL1      8'h00
`define PIA_OFF_CTL2      8'h04
`define PIA_OFF_CTL3      8'h08
`define PIA_OFF_CTL4      8'h0C
`define PIA_OFF_FLAGS     8'h10
`define PIA_OFF_ENABLE    8'h14
`define PIA_OFF_PRIO0     8'h18
`define PIA_OFF_STATUS    8'h28
`define PIA_OFF_PSW       8'h2C
`define PIA_OFF_CORE      8'h30
`define PIA_OFF_ALTREG    8'h34
`define PIA_RST_ZERO      16'h0000
`define PIA_RST_CTL2      16'h8000
`define PIA_RST_PRIO      16'h4444
`define PIA_MASK_CTL1     16'hFFFE
`define PIA_MASK_CTL2     16'h811F
`define PIA_MASK_CTL3     16'h0171
`define PIA_MASK_CTL4     16'h0001
`define PIA_MASK_PRIO     16'h7777
`define PIA_MASK_ALT      16'h0777
`define PIA_BIT_NEST_DIS  15
`define PIA_BIT_GLOBAL_EN 15
`define PIA_BIT_ALT_VT    8
`define PIA_NUM_EXT       5
`define PIA_PSW_IPL_LSB   5
`define PIA_CORE_TRAP_BIT 3
`define PIA_PRIO_W        3
`define PIA_NIB_W         4
`define PIA_IPL_ALL_MASK  3'h7
`define PIA_RESP_OKAY     2'h0
`define PIA_RESP_SLVERR   2'h2
`endif

// [hw/pia_pkg.sv]
// shared types of the interrupt arbiter
package pia_pkg;
    typedef logic [2:0] pia_prio_t;
    typedef logic [3:0] pia_level_t;
    typedef logic [3:0] pia_idx_t;
    typedef logic [7:0] pia_vec_t;
endpackage : pia_pkg

// [hw/pia_arbiter.sv]
// combinational winner search over pending sources
`timescale 1ns/1ps
`include "pia_defs.svh"
module pia_arbiter #(
    parameter int NSRC = 16
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [NSRC-1:0]            pend,
    input  wire logic [NSRC*`PIA_PRIO_W-1:0] prio_flat,
    output logic                            win_valid,
    output pia_pkg::pia_idx_t               win_idx,
    output pia_pkg::pia_prio_t              win_prio
);

    // scan from the top vector down so that ties settle on the lowest vector
    always_comb
    begin
        win_valid = 1'b0;
        win_idx   = 4'h0;
        win_prio  = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (pend[i] && prio_flat[i*`PIA_PRIO_W +: `PIA_PRIO_W] != 3'h0 &&
                prio_flat[i*`PIA_PRIO_W +: `PIA_PRIO_W] >= win_prio) // RULE2 RULE3 RULE4
            begin
                win_valid = 1'b1;
                win_idx   = 4'(i);
                win_prio  = prio_flat[i*`PIA_PRIO_W +: `PIA_PRIO_W];
            end
        end
    end

    // helper: true when some other pending source should have won
    function automatic logic better_exists(input pia_pkg::pia_idx_t w,
                                           input pia_pkg::pia_prio_t p);
        logic found;
        pia_pkg::pia_prio_t q;
        found = 1'b0;
        for (int i = 0; i < NSRC; i++)
        begin
            q = prio_flat[i*`PIA_PRIO_W +: `PIA_PRIO_W];
            if (pend[i] && q != 3'h0 && (q > p || (q == p && 4'(i) < w)))
                found = 1'b1;
        end
        return found;
    endfunction : better_exists

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_zero_prio_excluded: assert property ( // RULE3
        win_valid |-> win_prio != 3'h0 &&
            prio_flat[win_idx*`PIA_PRIO_W +: `PIA_PRIO_W] == win_prio && pend[win_idx])
        else $error("zero priority or idle source chosen");

    a_tie_lowest_vector: assert property ( // RULE4
        win_valid |-> !better_exists(win_idx, win_prio))
        else $error("winner is not the best pending source");

    a_none_left_out: assert property ( // RULE2
        !win_valid |-> !better_exists(4'h0, 3'h0))
        else $error("pending source present but no winner");

endmodule : pia_arbiter

// [hw/pia_top.sv]
// interrupt arbiter: axi4-lite registers, request capture, core request port
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pia_defs.svh"
// Behaviour
// RULE1: priority sits in low three bits of each nibble; nibble top reads zero
// RULE2: user priorities 1 lowest to 7 highest rank the sources
// RULE3: a source with priority zero is never taken
// RULE4: highest priority wins; ties go to the lowest vector number
// RULE5: during an exception only strictly higher priority may preempt
// RULE6: equal priority lower vector arriving during an exception stays pending
// RULE7: hardware sets each request flag; software clears it
// RULE8: a source requests only while its enable bit is set
// RULE9: status latches winner vector number and its new level
// RULE10: software writes the three cpu priority bits, effective at once
// RULE11: software can clear but never set the trap level bit
// RULE12: control one holds nesting disable on top plus trap flags and enables
// RULE13: control two holds global enable, alternate table enable, edge polarities
// RULE14: control three holds soft trap status; control four the hard trap bit
// RULE15: a register holds level and two alternate context selects
// RULE16: a request starts only when above the 4-bit cpu priority
// RULE17: user sources reach levels 1 to 7; 8 to 15 belong to traps
// RULE18: cpu priority bits at 111 mask every user source
// RULE19: nesting disable makes the cpu priority bits read-only to software
// RULE20: pending is flag, enable and nonzero priority; one request plus vector out
module pia_top #(
    parameter int                NSRC     = 16,
    parameter pia_pkg::pia_vec_t VEC_BASE = 8'h00
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [NSRC-1:0] src_req,
    input  wire logic [15:0] soft_trap_set,
    input  wire logic        trap_level_set,
    input  wire logic        cpu_irq_ack,
    input  wire logic        core_ipl_load,
    input  wire logic [3:0]  core_ipl_value,
    output logic             cpu_irq_req,
    output pia_pkg::pia_vec_t   cpu_irq_vector,
    output pia_pkg::pia_level_t cpu_irq_level,
    output pia_pkg::pia_level_t cpu_priority,
    output logic             alt_vector_table_enable
);

    localparam int         NBANK   = NSRC / 4;
    localparam logic [5:0] NBANK_W = 6'(NSRC / 4);

    // the winner index is four bits and the flag bank one 16-bit register
    if (NSRC < 4 || NSRC > 16 || NSRC % 4 != 0)
    begin : g_bad_nsrc
        $error("NSRC must be 4, 8, 12 or 16");
    end

    logic [15:0]     ctl1_reg;
    logic [15:0]     ctl2_reg;
    logic [15:0]     ctl3_reg;
    logic [15:0]     ctl4_reg;
    logic [15:0]     alt_reg;
    logic [NSRC-1:0] flags_reg;
    logic [NSRC-1:0] en_reg;
    logic [15:0]     prio_reg [NBANK];
    logic [2:0]      ipl_reg;
    logic            trap_bit_reg;
    logic            busy_reg;
    logic            req_reg;
    pia_pkg::pia_vec_t   vec_reg;
    pia_pkg::pia_level_t lvl_reg;
    logic [NSRC-1:0] sync1_reg;
    logic [NSRC-1:0] sync2_reg;
    logic [NSRC-1:0] sync3_reg;
    logic [NSRC-1:0] flag_set;
    logic [NSRC-1:0] pend;
    logic [NSRC*`PIA_PRIO_W-1:0] prio_flat;
    logic            win_valid;
    pia_pkg::pia_idx_t   win_idx;
    pia_pkg::pia_prio_t  win_prio;
    logic            aw_held_reg;
    logic            w_held_reg;
    logic [7:0]      wr_addr_reg;
    logic [15:0]     wr_data_reg;
    logic [1:0]      wr_strb_reg;
    logic            bvalid_reg;
    logic [1:0]      bresp_reg;
    logic            rvalid_reg;
    logic [1:0]      rresp_reg;
    logic [15:0]     rdata_reg;
    logic [15:0]     rd_data;
    logic            wr_fire;
    logic            nest_dis;
    logic            global_request_enable;
    pia_pkg::pia_level_t cpu_level;

    // byte lanes 0 and 1 carry the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] d,
                                            input logic [1:0]  s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic prio_hit(input logic [7:0] a);
        logic [7:0] d;
        d = a - `PIA_OFF_PRIO0;
        return a >= `PIA_OFF_PRIO0 && d[7:2] < NBANK_W && a[1:0] == 2'h0;
    endfunction : prio_hit

    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `PIA_OFF_CTL1, `PIA_OFF_CTL2, `PIA_OFF_CTL3, `PIA_OFF_CTL4,
            `PIA_OFF_FLAGS, `PIA_OFF_ENABLE, `PIA_OFF_STATUS,
            `PIA_OFF_PSW, `PIA_OFF_CORE, `PIA_OFF_ALTREG: return 1'b1;
            default: return prio_hit(a);
        endcase
    endfunction : addr_ok

    function automatic logic wr_hit(input logic [7:0] off);
        return wr_fire && wr_addr_reg == off;
    endfunction : wr_hit

    function automatic pia_pkg::pia_prio_t prio_of(input int i);
        return prio_reg[i / 4][(i % 4) * `PIA_NIB_W +: `PIA_PRIO_W]; // RULE1
    endfunction : prio_of

    assign nest_dis  = ctl1_reg[`PIA_BIT_NEST_DIS];
    assign global_request_enable       = ctl2_reg[`PIA_BIT_GLOBAL_EN];
    assign cpu_level = {trap_bit_reg, ipl_reg}; // RULE16
    assign wr_fire   = aw_held_reg && w_held_reg;

    // write channel: address and data taken in either order, response after both
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 16'h0000;
            wr_strb_reg <= 2'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `PIA_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                wr_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg  <= 1'b1;
                wr_data_reg <= s_axi_wdata[15:0];
                wr_strb_reg <= s_axi_wstrb[1:0];
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= addr_ok(wr_addr_reg) ? `PIA_RESP_OKAY : `PIA_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // read mux; unmapped words read zero and answer slverr
    always_comb
    begin
        rd_data = 16'h0000;
        case (s_axi_araddr)
            `PIA_OFF_CTL1:   rd_data = ctl1_reg;
            `PIA_OFF_CTL2:   rd_data = ctl2_reg;
            `PIA_OFF_CTL3:   rd_data = ctl3_reg;
            `PIA_OFF_CTL4:   rd_data = ctl4_reg;
            `PIA_OFF_FLAGS:  rd_data = 16'(flags_reg);
            `PIA_OFF_ENABLE: rd_data = 16'(en_reg);
            `PIA_OFF_STATUS: rd_data = {4'h0, lvl_reg, vec_reg}; // RULE9
            `PIA_OFF_PSW:    rd_data = 16'({ipl_reg, 5'h00});
            `PIA_OFF_CORE:   rd_data = 16'({trap_bit_reg, 3'h0});
            `PIA_OFF_ALTREG: rd_data = alt_reg; // RULE15
            default:
            begin
                if (prio_hit(s_axi_araddr))
                    rd_data = prio_reg[2'((s_axi_araddr - `PIA_OFF_PRIO0) >> 2)];
            end
        endcase
    end

    // read channel: one word in flight, rdata held until rready
    assign s_axi_arready = !rvalid_reg;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `PIA_RESP_OKAY;
            rdata_reg  <= 16'h0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_data;
            rresp_reg  <= addr_ok(s_axi_araddr) ? `PIA_RESP_OKAY : `PIA_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = {16'h0000, rdata_reg};

    // control words; unimplemented bits are masked so they read zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctl1_reg <= `PIA_RST_ZERO;
            ctl2_reg <= `PIA_RST_CTL2;
            ctl3_reg <= `PIA_RST_ZERO;
            ctl4_reg <= `PIA_RST_ZERO;
            alt_reg  <= `PIA_RST_ZERO;
        end
        else
        begin
            if (wr_hit(`PIA_OFF_CTL1)) // RULE12
                ctl1_reg <= merge16(ctl1_reg, wr_data_reg, wr_strb_reg) & `PIA_MASK_CTL1;
            if (wr_hit(`PIA_OFF_CTL2)) // RULE13
                ctl2_reg <= merge16(ctl2_reg, wr_data_reg, wr_strb_reg) & `PIA_MASK_CTL2;
            // a trap event in the clearing cycle survives the clear
            if (wr_hit(`PIA_OFF_CTL3)) // RULE14
                ctl3_reg <= (merge16(ctl3_reg, wr_data_reg, wr_strb_reg) | soft_trap_set)
                            & `PIA_MASK_CTL3;
            else
                ctl3_reg <= (ctl3_reg | soft_trap_set) & `PIA_MASK_CTL3;
            if (wr_hit(`PIA_OFF_CTL4)) // RULE14
                ctl4_reg <= merge16(ctl4_reg, wr_data_reg, wr_strb_reg) & `PIA_MASK_CTL4;
            if (wr_hit(`PIA_OFF_ALTREG)) // RULE15
                alt_reg <= merge16(alt_reg, wr_data_reg, wr_strb_reg) & `PIA_MASK_ALT;
        end
    end
    assign alt_vector_table_enable = ctl2_reg[`PIA_BIT_ALT_VT];

    // source pins: two flops, then a third for the edge; low inputs pick polarity
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end
        else
        begin
            sync1_reg <= src_req;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    always_comb
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            if (i < `PIA_NUM_EXT && ctl2_reg[i])
                flag_set[i] = !sync2_reg[i] && sync3_reg[i];
            else
                flag_set[i] = sync2_reg[i] && !sync3_reg[i];
        end
    end

    // flags, enables and priorities; a new event wins over a clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flags_reg <= '0;
            en_reg    <= '0;
            for (int k = 0; k < NBANK; k++)
                prio_reg[k] <= `PIA_RST_PRIO;
        end
        else
        begin
            if (wr_hit(`PIA_OFF_FLAGS))
                flags_reg <= NSRC'(merge16(16'(flags_reg), wr_data_reg, wr_strb_reg))
                             | flag_set; // RULE7
            else
                flags_reg <= flags_reg | flag_set; // RULE7
            if (wr_hit(`PIA_OFF_ENABLE))
                en_reg <= NSRC'(merge16(16'(en_reg), wr_data_reg, wr_strb_reg));
            for (int k = 0; k < NBANK; k++)
            begin
                if (wr_fire && prio_hit(wr_addr_reg) &&
                    2'((wr_addr_reg - `PIA_OFF_PRIO0) >> 2) == 2'(k))
                    prio_reg[k] <= merge16(prio_reg[k], wr_data_reg, wr_strb_reg)
                                   & `PIA_MASK_PRIO; // RULE1
            end
        end
    end

    // pending terms feed the winner search
    always_comb
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            prio_flat[i*`PIA_PRIO_W +: `PIA_PRIO_W] = prio_of(i);
            pend[i] = flags_reg[i] && en_reg[i] && prio_of(i) != 3'h0; // RULE3 RULE8 RULE20
        end
    end

    pia_arbiter #(
        .NSRC      (NSRC)
    ) u_arb (
        .clk       (clk),
        .rst_n     (rst_n),
        .pend      (pend),
        .prio_flat (prio_flat),
        .win_valid (win_valid),
        .win_idx   (win_idx),
        .win_prio  (win_prio)
    );

    // cpu priority: entry raises it to the taken level, the core may reload it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ipl_reg      <= 3'h0;
            trap_bit_reg <= 1'b0;
            busy_reg     <= 1'b0;
        end
        else
        begin
            if (cpu_irq_ack && req_reg)
                ipl_reg <= lvl_reg[2:0]; // RULE5 RULE6
            else if (core_ipl_load)
                ipl_reg <= core_ipl_value[2:0];
            else if (wr_hit(`PIA_OFF_PSW) && !nest_dis) // RULE10 RULE19
                ipl_reg <= wr_data_reg[`PIA_PSW_IPL_LSB +: 3];
            // software may only clear; a trap entry in the same cycle still sets
            if (trap_level_set || (core_ipl_load && core_ipl_value[3]))
                trap_bit_reg <= 1'b1;
            else if (core_ipl_load)
                trap_bit_reg <= 1'b0;
            else if (wr_hit(`PIA_OFF_CORE) && wr_strb_reg[0] &&
                     !wr_data_reg[`PIA_CORE_TRAP_BIT])
                trap_bit_reg <= 1'b0; // RULE11
            if (cpu_irq_ack && req_reg)
                busy_reg <= 1'b1;
            else if (core_ipl_load)
                busy_reg <= 1'b0;
        end
    end

    // status latch and request; user levels never exceed 7 so traps stay above
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            vec_reg <= 8'h00;
            lvl_reg <= 4'h0;
            req_reg <= 1'b0;
        end
        else
        begin
            if (win_valid)
            begin
                vec_reg <= VEC_BASE + {4'h0, win_idx}; // RULE9
                lvl_reg <= {1'b0, win_prio}; // RULE17
            end
            req_reg <= global_request_enable && win_valid && !cpu_irq_ack &&
                       {1'b0, win_prio} > cpu_level && // RULE16 RULE18
                       !(nest_dis && busy_reg);
        end
    end
    assign cpu_irq_req    = req_reg;
    assign cpu_irq_vector = vec_reg;
    assign cpu_irq_level  = lvl_reg;
    assign cpu_priority   = cpu_level;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_entry;
        cpu_irq_req && cpu_irq_ack;
    endsequence
    sequence s_raised(pia_pkg::pia_prio_t p);
        !cpu_irq_req && ipl_reg == p;
    endsequence

    a_nibble_top_zero: assert property ( // RULE1
        prio_reg[0][3] == 1'b0 && prio_reg[0][7] == 1'b0 &&
        prio_reg[0][11] == 1'b0 && prio_reg[0][15] == 1'b0)
        else $error("priority nibble top bit set");
    a_req_above_cpu: assert property ( // RULE16
        cpu_irq_req |-> $past(global_request_enable) && $past({1'b0, win_prio}) > $past(cpu_level))
        else $error("request not above cpu priority");
    a_all_user_masked: assert property ( // RULE18
        ipl_reg == `PIA_IPL_ALL_MASK |=> !cpu_irq_req)
        else $error("request while user sources masked");
    a_entry_no_equal: assert property ( // RULE5
        s_entry |=> s_raised($past(cpu_irq_level[2:0])))
        else $error("entry did not raise cpu priority");
    a_status_latch: assert property ( // RULE9
        win_valid |=> vec_reg == VEC_BASE + {4'h0, $past(win_idx)} &&
                      lvl_reg == {1'b0, $past(win_prio)})
        else $error("status not latched from winner");
    a_flag_set_wins: assert property ( // RULE7
        flag_set != '0 |=> (flags_reg & $past(flag_set)) == $past(flag_set))
        else $error("request event lost");
    a_trap_no_sw_set: assert property ( // RULE11
        $rose(trap_bit_reg) |-> $past(trap_level_set) ||
                                ($past(core_ipl_load) && $past(core_ipl_value[3])))
        else $error("trap level bit set without trap");
    a_ipl_locked: assert property ( // RULE19
        nest_dis && !cpu_irq_ack && !core_ipl_load |=> $stable(ipl_reg))
        else $error("cpu priority changed while nesting disabled");
    a_winner_enabled: assert property ( // RULE8
        win_valid |-> en_reg[win_idx] && flags_reg[win_idx])
        else $error("winner not flagged and enabled");

endmodule : pia_top

// [verification/pia_core_model.sv]
// processor core model: takes each request and records what it took
`timescale 1ns/1ps
module pia_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       req,
    input  wire logic [7:0] vec,
    input  wire logic [3:0] lvl,
    output logic            ack,
    output int              n_ack,
    output logic [7:0]      l_vec,
    output logic [3:0]      l_lvl
);
    // one-cycle ack of the single combined request; vector taken on that edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack   <= 1'b0;
            n_ack <= 0;
            l_vec <= 8'h00;
            l_lvl <= 4'h0;
        end
        else
        begin
            ack <= req & !ack;
            if (req & ack)
            begin
                n_ack <= n_ack + 1;
                l_vec <= vec;
                l_lvl <= lvl;
            end
        end
    end
endmodule : pia_core_model

// [verification/tb_top.sv]
// self-checking bench of the interrupt arbiter
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst_n, awv, wv, bri, arv, rr, ld, ack, req, ave, tls;
    logic        awrdy, wrdy, bv, arrdy, rv;
    logic [7:0]  awa, ara, vec, lvec;
    logic [31:0] wd, rdat;
    logic [3:0]  ws, lvl, cpri, llvl, ldv;
    logic [1:0]  br, rrs, rsp, bq;
    logic [15:0] sr, got, sts;
    int          err_count, total_checks, na, cyc;
    pia_top u_pia_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bri), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .src_req(sr), .soft_trap_set(sts), .trap_level_set(tls),
        .cpu_irq_ack(ack), .core_ipl_load(ld), .core_ipl_value(ldv), .cpu_irq_req(req),
        .cpu_irq_vector(vec), .cpu_irq_level(lvl), .cpu_priority(cpri),
        .alt_vector_table_enable(ave));
    pia_core_model u_pia_core_model (.clk(clk), .rst_n(rst_n), .req(req), .vec(vec),
        .lvl(lvl), .ack(ack), .n_ack(na), .l_vec(lvec), .l_lvl(llvl));
    // free-running clock, 20 ns
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // ready is sampled mid-cycle; it cannot move before the next rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awa <= a;
        wd <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bri <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = awv & awrdy;
            tw = wv & wrdy;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (awv | wv);
        do
        begin
            @(negedge clk);
            tb = bv;
            bq = br;
            @(posedge clk);
        end while (!tb);
        bri <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
        logic t;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(negedge clk);
            t = arrdy;
            @(posedge clk);
        end while (!t);
        arv <= 1'b0;
        do
        begin
            @(negedge clk);
            t = rv;
            d = rdat[15:0];
            r = rrs;
            @(posedge clk);
        end while (!t);
        rr <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        rd(a, got, rsp);
        chk(got, e);
    endtask : rc
    // core side: count of takes plus last vector and level after settling
    task automatic core(input int n, input logic [7:0] v, input logic [3:0] l);
        repeat (12) @(posedge clk);
        chk(na[15:0], n[15:0]);
        chk({4'h0, llvl, lvec}, {4'h0, l, v});
    endtask : core
    task automatic ret(input logic [3:0] v);
        @(posedge clk);
        ldv <= v;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
    endtask : ret
    task automatic t_reset;
        rc(8'h04, 16'h8000);
        rc(8'h28, 16'h0000);
        rc(8'h18, 16'h4444);
        wr(8'h18, 16'hFFFF);
        chk({14'h0000, bq}, 16'h0000);
        rc(8'h18, 16'h7777);
        rd(8'h3C, got, rsp);
        chk({14'h0000, rsp}, 16'h0002);
        wr(8'h3C, 16'hFFFF);
        chk({14'h0000, bq}, 16'h0002);
    endtask : t_reset
    // src0 prio 0, src1 3, src2 and src3 5; src4 flagged but disabled
    task automatic t_arb;
        wr(8'h14, 16'h000F);
        wr(8'h18, 16'h5530);
        sr <= 16'h001F;
        core(1, 8'h02, 4'h5);
        rc(8'h10, 16'h001F);
        rc(8'h28, 16'h0502);
        chk({12'h000, cpri}, 16'h0005);
        core(1, 8'h02, 4'h5);
        wr(8'h18, 16'h5560);
        core(2, 8'h01, 4'h6);
        wr(8'h10, 16'h0019);
        ret(4'h0);
        core(3, 8'h03, 4'h5);
        wr(8'h10, 16'h0011);
        ret(4'h0);
        core(3, 8'h03, 4'h5);
    endtask : t_arb
    task automatic t_mask;
        wr(8'h2C, 16'h00E0);
        wr(8'h14, 16'h0010);
        core(3, 8'h03, 4'h5);
        rc(8'h2C, 16'h00E0);
        wr(8'h2C, 16'h0080);
        core(3, 8'h03, 4'h5);
        wr(8'h2C, 16'h0060);
        core(4, 8'h04, 4'h4);
        wr(8'h00, 16'h8000);
        wr(8'h2C, 16'h0000);
        rc(8'h2C, 16'h0080);
        rc(8'h00, 16'h8000);
        wr(8'h30, 16'h0008);
        rc(8'h30, 16'h0000);
        wr(8'h04, 16'h8100);
        chk({15'h0000, ave}, 16'h0001);
    endtask : t_mask
    // trap entry lifts the level above all user sources; soft traps latch until cleared
    task automatic t_trap;
        @(posedge clk);
        tls <= 1'b1;
        sts <= 16'hFFFF;
        @(posedge clk);
        tls <= 1'b0;
        sts <= 16'h0000;
        rc(8'h30, 16'h0008);
        chk({12'h000, cpri}, 16'h000C);
        wr(8'h30, 16'h0000);
        rc(8'h30, 16'h0000);
        rc(8'h08, 16'h0171);
        wr(8'h08, 16'h0000);
        rc(8'h08, 16'h0000);
        wr(8'h0C, 16'hFFFF);
        rc(8'h0C, 16'h0001);
        wr(8'h34, 16'hFFFF);
        rc(8'h34, 16'h0777);
        wr(8'h10, 16'h0000);
        wr(8'h04, 16'h8101);
        sr <= 16'h001E;
        repeat (6) @(posedge clk);
        rc(8'h10, 16'h0001);
    endtask : t_trap
    task automatic final_report;
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // a hung handshake is cut short here
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            final_report;
        end
    end
    initial
    begin
        {rst_n, awv, wv, bri, arv, rr, ld, tls} = 8'h00;
        {awa, ara, wd, ldv, sr, sts} = 84'h0;
        ws = 4'h3;
        err_count = 0;
        total_checks = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_arb;
        t_mask;
        t_trap;
        final_report;
    end
endmodule : tb_top
